//--- rtl/ipwdt_core.v
`timescale 1ns/1ps
`include "ipwdt_regs.vh"

module ipwdt_core #(
  parameter CLK_HZ = `IPWDT_CLK_HZ, // clock rate in hertz
  parameter SEC_PER_MIN = `IPWDT_SEC_PER_MIN // seconds in a minute
) (
  input wire ref_clk, // 40 MHz clock
  input wire resetn, // async reset, active low
  input wire [7:0] ioAddr, // i/o port address
  input wire [7:0] ioWdata, // i/o write data
  input wire ioWr, // one-cycle write strobe
  input wire ioRd, // one-cycle read strobe
  output reg [7:0] ioRdata_ff, // read data, valid the cycle after ioRd
  input wire kbdActivity, // keyboard activity pulse
  input wire timeout_action_strap, // 1: reset on expiry, 0: interrupt
  output reg wdtIrq_n_ff, // interrupt, active low level
  output reg wdtRst_n_ff // reset request, active low level
);

////////////////////////////////////////////////////////////////////////
// register state
reg [7:0] index_ff; // last index written
reg unlockHalf_ff; // first unlock key seen
reg cfgMode_ff; // configuration unlocked
reg [7:0] ldn_ff; // logical device select
reg active_ff; // watchdog enable
reg [7:0] unit_ff; // unit register image
reg [7:0] count_ff; // running count
reg kbdEn_ff; // keyboard reload enable
reg status_ff; // timed-out flag
reg strapLatched_ff; // strap captured after reset release
reg strapTaken_ff; // strap capture done

wire secTick;
wire minTick;

// reload restarts the prescaler too
wire isIndex = (ioAddr == `IPWDT_PORT_INDEX);
wire isData = (ioAddr == `IPWDT_PORT_DATA);
wire wdtSel = cfgMode_ff && (ldn_ff == `IPWDT_LDN_WATCHDOG);
wire dataWr = ioWr && isData && cfgMode_ff;
wire countWr = dataWr && wdtSel && (index_ff == `IPWDT_REG_COUNT);
wire ctrlWr = dataWr && wdtSel && (index_ff == `IPWDT_REG_CTRL);
wire forceTo = ctrlWr && ioWdata[`IPWDT_FORCE_BIT];
wire kbdReload = kbdEn_ff && kbdActivity && active_ff;
wire reload = countWr || kbdReload;
wire unitTick = unit_ff[`IPWDT_UNIT_BIT] ? minTick : secTick;
wire expire = active_ff && (count_ff == 8'h01) && unitTick && !reload;

////////////////////////////////////////////////////////////////////////
// decoding of a watchdog register index, used by the read path only
function isWdtReg;
  input [7:0] idx;
  begin
    isWdtReg = (idx == `IPWDT_REG_ACTIVATE) || (idx == `IPWDT_REG_UNIT) ||
      (idx == `IPWDT_REG_COUNT) || (idx == `IPWDT_REG_CTRL);
  end
endfunction

////////////////////////////////////////////////////////////////////////
ipwdt_tick_gen #(
  .CLK_HZ(CLK_HZ),
  .SEC_PER_MIN(SEC_PER_MIN)
) u_tick (
  .ref_clk(ref_clk),
  .resetn(resetn),
  .tickClr(reload),
  .secTick_ff(secTick),
  .minTick_ff(minTick)
);

////////////////////////////////////////////////////////////////////////
// index port: key detection and register index
always @(posedge ref_clk or negedge resetn) begin
  if (!resetn) begin
    index_ff <= `IPWDT_RST_BYTE;
    unlockHalf_ff <= 1'b0;
    cfgMode_ff <= 1'b0;
  end else if (ioWr && isIndex) begin
    if (ioWdata == `IPWDT_KEY_LOCK && cfgMode_ff) begin
      cfgMode_ff <= 1'b0;
      unlockHalf_ff <= 1'b0;
    end else if (ioWdata == `IPWDT_KEY_UNLOCK && !cfgMode_ff) begin
      // second key in succession unlocks
      cfgMode_ff <= unlockHalf_ff;
      unlockHalf_ff <= ~unlockHalf_ff;
    end else begin
      unlockHalf_ff <= 1'b0; // any other value breaks the sequence
      if (cfgMode_ff) begin
        index_ff <= ioWdata;
      end
    end
  end else if (ioWr && isData) begin
    unlockHalf_ff <= 1'b0; // key writes must be back to back
  end
end

////////////////////////////////////////////////////////////////////////
// data port writes into configuration registers
always @(posedge ref_clk or negedge resetn) begin
  if (!resetn) begin
    ldn_ff <= `IPWDT_RST_BYTE;
    active_ff <= 1'b0;
    unit_ff <= `IPWDT_RST_BYTE;
    kbdEn_ff <= 1'b0;
  end else if (dataWr) begin
    if (index_ff == `IPWDT_REG_DEVSEL) begin
      ldn_ff <= ioWdata;
    end else if (wdtSel && index_ff == `IPWDT_REG_ACTIVATE) begin
      active_ff <= ioWdata[`IPWDT_ACT_BIT];
    end else if (wdtSel && index_ff == `IPWDT_REG_UNIT) begin
      unit_ff <= ioWdata;
    end else if (ctrlWr) begin
      kbdEn_ff <= ioWdata[`IPWDT_KBD_BIT];
    end
  end
end

////////////////////////////////////////////////////////////////////////
// countdown: the reload value is kept so keyboard activity can reuse it
reg [7:0] loadVal_ff; // last value written to the count register
always @(posedge ref_clk or negedge resetn) begin
  if (!resetn) begin
    loadVal_ff <= `IPWDT_RST_BYTE;
    count_ff <= `IPWDT_RST_BYTE;
  end else if (countWr) begin
    loadVal_ff <= ioWdata;
    count_ff <= ioWdata;
  end else if (kbdReload) begin
    count_ff <= loadVal_ff;
  end else if (active_ff && count_ff != 8'h00 && unitTick) begin
    count_ff <= count_ff - 8'h01; // zero holds the timer stopped
  end
end

////////////////////////////////////////////////////////////////////////
// strap is static; capture once after reset release, never in reset
always @(posedge ref_clk or negedge resetn) begin
  if (!resetn) begin
    strapLatched_ff <= 1'b0;
    strapTaken_ff <= 1'b0;
  end else if (!strapTaken_ff) begin
    strapLatched_ff <= timeout_action_strap;
    strapTaken_ff <= 1'b1;
  end
end

////////////////////////////////////////////////////////////////////////
// timeout status and outputs; a forced timeout wins over a same-cycle clear, a same-cycle reload blocks expiry
always @(posedge ref_clk or negedge resetn) begin
  if (!resetn) begin
    status_ff <= 1'b0;
    wdtIrq_n_ff <= 1'b1;
    wdtRst_n_ff <= 1'b1;
  end else begin
    if (expire || forceTo) begin
      status_ff <= 1'b1;
      wdtIrq_n_ff <= strapLatched_ff;
      wdtRst_n_ff <= ~strapLatched_ff;
    end else if (reload) begin
      // a count write or keyboard reload ends the held level
      status_ff <= 1'b0;
      wdtIrq_n_ff <= 1'b1;
      wdtRst_n_ff <= 1'b1;
    end
  end
end

////////////////////////////////////////////////////////////////////////
// read path; force bit always reads zero since it self-clears
always @(posedge ref_clk or negedge resetn) begin
  if (!resetn) begin
    ioRdata_ff <= `IPWDT_RST_BYTE;
  end else if (ioRd) begin
    ioRdata_ff <= 8'h00;
    if (isIndex && cfgMode_ff) begin
      ioRdata_ff <= index_ff;
    end else if (isData && cfgMode_ff) begin
      if (index_ff == `IPWDT_REG_DEVSEL) begin
        ioRdata_ff <= ldn_ff;
      end else if (wdtSel && isWdtReg(index_ff)) begin
        case (index_ff)
          `IPWDT_REG_ACTIVATE: ioRdata_ff <= {7'h00, active_ff};
          `IPWDT_REG_UNIT: ioRdata_ff <= unit_ff;
          `IPWDT_REG_COUNT: ioRdata_ff <= count_ff;
          default: ioRdata_ff <= {1'b0, kbdEn_ff, 1'b0, status_ff, 4'h0};
        endcase
      end
    end
  end
end

endmodule

//--- rtl/ipwdt_regs.vh
`ifndef IPWDT_REGS_VH
`define IPWDT_REGS_VH
// i/o port addresses (all eight address bits are compared; 2E is index, 2F is data)
`define IPWDT_PORT_INDEX 8'h2E
`define IPWDT_PORT_DATA 8'h2F
// index-port key values
`define IPWDT_KEY_UNLOCK 8'h87
`define IPWDT_KEY_LOCK 8'hAA
// register indexes
`define IPWDT_REG_DEVSEL 8'h07
`define IPWDT_REG_ACTIVATE 8'h30
`define IPWDT_REG_UNIT 8'hF5
`define IPWDT_REG_COUNT 8'hF6
`define IPWDT_REG_CTRL 8'hF7
// values and field positions
`define IPWDT_LDN_WATCHDOG 8'h08
`define IPWDT_ACT_BIT 0
`define IPWDT_UNIT_BIT 3
`define IPWDT_KBD_BIT 6
`define IPWDT_FORCE_BIT 5
`define IPWDT_STAT_BIT 4
// reset values
`define IPWDT_RST_BYTE 8'h00
// timing
`define IPWDT_CLK_HZ 40000000
`define IPWDT_SEC_PER_MIN 60
`endif

//--- rtl/ipwdt_tick_gen.v
`timescale 1ns/1ps
`include "ipwdt_regs.vh"
// one-cycle second and minute pulses derived from ref_clk
module ipwdt_tick_gen #(
  parameter CLK_HZ = `IPWDT_CLK_HZ,
  parameter SEC_PER_MIN = `IPWDT_SEC_PER_MIN
) (
  input wire ref_clk, // system clock
  input wire resetn, // async reset, active low
  input wire tickClr, // restart the prescaler (reload)
  output reg secTick_ff, // one-second pulse
  output reg minTick_ff // one-minute pulse
);

////////////////////////////////////////////////////////////////////////
reg [31:0] preCnt_ff; // cycles within the current second
reg [7:0] secCnt_ff; // seconds within the current minute
wire secEnd = (preCnt_ff == CLK_HZ - 1);
wire minEnd = (secCnt_ff == SEC_PER_MIN - 1);

// prescaler restarts on reload so a refresh gives a full first unit
always @(posedge ref_clk or negedge resetn) begin
  if (!resetn) begin
    preCnt_ff <= 32'h0000_0000;
    secCnt_ff <= 8'h00;
    secTick_ff <= 1'b0;
    minTick_ff <= 1'b0;
  end else if (tickClr) begin
    preCnt_ff <= 32'h0000_0000;
    secCnt_ff <= 8'h00;
    secTick_ff <= 1'b0;
    minTick_ff <= 1'b0;
  end else begin
    secTick_ff <= secEnd;
    minTick_ff <= secEnd && minEnd;
    if (secEnd) begin
      preCnt_ff <= 32'h0000_0000;
      secCnt_ff <= minEnd ? 8'h00 : secCnt_ff + 8'h01;
    end else begin
      preCnt_ff <= preCnt_ff + 32'h0000_0001;
    end
  end
end

endmodule

//--- verification/ipwdt_core_sva.sv
`timescale 1ns/1ps
// port-level timing of the watchdog core
module ipwdt_sva #(
  parameter CLK_HZ = 10, // cycles per second
  parameter SEC_PER_MIN = 3 // seconds per minute
) (
  input wire logic ref_clk, // clock
  input wire logic resetn, // async reset, active low
  input wire logic [7:0] ioAddr, // port address
  input wire logic [7:0] ioWdata, // write data
  input wire logic ioWr, // write strobe
  input wire logic ioRd, // read strobe
  input wire logic [7:0] ioRdata_ff, // read data
  input wire logic kbdActivity, // keyboard pulse
  input wire logic timeout_action_strap, // expiry action
  input wire logic wdtIrq_n_ff, // interrupt, active low
  input wire logic wdtRst_n_ff // reset request, active low
);
  //////////////////////////////////////////////////
  logic [7:0] idxSeen_ff; // last byte sent to the index port
  // shadow of the index, so a data-port read can be tied to its register
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      idxSeen_ff <= 8'h00;
    end else if (ioWr && ioAddr == 8'h2e) begin
      idxSeen_ff <= ioWdata;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  outs_exclusive_a: assert property (wdtIrq_n_ff || wdtRst_n_ff)
    else $error("both expiry outputs low");
  strap_irq_a: assert property (timeout_action_strap |-> wdtIrq_n_ff)
    else $error("interrupt low with reset action strapped");
  strap_rst_a: assert property (!timeout_action_strap |-> wdtRst_n_ff)
    else $error("reset low with interrupt action strapped");
  irq_release_a: assert property ($rose(wdtIrq_n_ff) |->
    $past(ioWr) || $past(ioWr, 2) || $past(kbdActivity) || $past(kbdActivity, 2))
    else $error("interrupt released without a reload");
  rst_release_a: assert property ($rose(wdtRst_n_ff) |->
    $past(ioWr) || $past(ioWr, 2) || $past(kbdActivity) || $past(kbdActivity, 2))
    else $error("reset request released without a reload");
  rd_unmapped_a: assert property (ioRd && ioAddr != 8'h2e && ioAddr != 8'h2f |=>
    ioRdata_ff == 8'h00)
    else $error("unmapped port read not zero");
  rdata_hold_a: assert property ($changed(ioRdata_ff) |-> $past(ioRd))
    else $error("read data moved without a read");
  force_selfclr_a: assert property (ioRd && ioAddr == 8'h2f && idxSeen_ff == 8'hf7 |=>
    !ioRdata_ff[5])
    else $error("force bit read back as one");
endmodule

bind ipwdt_core ipwdt_sva #(.CLK_HZ(CLK_HZ), .SEC_PER_MIN(SEC_PER_MIN)) ipwdt_sva_i (
  .ref_clk(ref_clk), .resetn(resetn), .ioAddr(ioAddr), .ioWdata(ioWdata), .ioWr(ioWr),
  .ioRd(ioRd), .ioRdata_ff(ioRdata_ff), .kbdActivity(kbdActivity),
  .timeout_action_strap(timeout_action_strap), .wdtIrq_n_ff(wdtIrq_n_ff),
  .wdtRst_n_ff(wdtRst_n_ff));

//--- verification/tb.sv
`timescale 1ns/1ps
// index/data port sequences against the watchdog core
module tb;
  logic ref_clk = 1'b0; // 40 MHz clock
  logic resetn = 1'b0; // async reset, active low
  logic ioWr = 1'b0, ioRd = 1'b0, kbdActivity = 1'b0, strap = 1'b0; // strobes, strap
  logic [7:0] ioAddr = 8'h00, ioWdata = 8'h00; // port address and data
  wire [7:0] ioRdata; // read data
  wire irqN, rstN; // expiry outputs
  int fail_count = 0, num_checks = 0, cycles = 0; // tallies
  //////////////////////////////////////////////////
  // short second and minute so each expiry takes a few dozen cycles
  ipwdt_core #(.CLK_HZ(10), .SEC_PER_MIN(3)) ipwdt_core_i (
    .ref_clk(ref_clk), .resetn(resetn), .ioAddr(ioAddr), .ioWdata(ioWdata), .ioWr(ioWr),
    .ioRd(ioRd), .ioRdata_ff(ioRdata), .kbdActivity(kbdActivity),
    .timeout_action_strap(strap), .wdtIrq_n_ff(irqN), .wdtRst_n_ff(rstN));
  initial forever #12.5 ref_clk = ~ref_clk;
  // cut a hung run short
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      wrap_up();
    end
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // one-cycle port write, launched just after an edge
  task automatic pw(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1 ioAddr = a; ioWdata = d; ioWr = 1'b1;
    @(posedge ref_clk);
    #1 ioWr = 1'b0;
  endtask
  // read data stays until the next read, so look one edge late
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    #1 ioAddr = a; ioRd = 1'b1;
    @(posedge ref_clk);
    #1 ioRd = 1'b0;
    @(posedge ref_clk);
    #1 chk(ioRdata, e);
  endtask
  task automatic rw(input logic [7:0] i, input logic [7:0] d);
    pw(8'h2e, i);
    pw(8'h2f, d);
  endtask
  task automatic rr(input logic [7:0] i, input logic [7:0] e);
    pw(8'h2e, i);
    rd(8'h2f, e);
  endtask
  // callers arrive on or just after a clock edge; step off it so the registered outputs have settled
  task automatic outs(input logic i, input logic r);
    #1 chk({6'h00, irqN, rstN}, {6'h00, i, r});
  endtask
  // the strap only changes while reset is held
  task automatic rst(input logic s);
    #1 resetn = 1'b0;
    strap = s;
    wt(3);
    #1 resetn = 1'b1;
    wt(2);
  endtask
  initial begin
    rst(1'b0);
    outs(1'b1, 1'b1);
    rd(8'h2f, 8'h00);
    pw(8'h2e, 8'h87);
    pw(8'h2e, 8'h87);
    rw(8'hf7, 8'h40);
    rr(8'hf7, 8'h00);
    rw(8'h07, 8'h08);
    rw(8'hf7, 8'h40);
    rr(8'hf7, 8'h40);
    rd(8'h40, 8'h00);
    rw(8'hf6, 8'h01);
    wt(20);
    outs(1'b1, 1'b1);
    rw(8'h30, 8'h01);
    rw(8'hf6, 8'h03);
    wt(27);
    outs(1'b1, 1'b1);
    wt(8);
    outs(1'b0, 1'b1);
    rr(8'hf7, 8'h50);
    wt(60);
    outs(1'b0, 1'b1);
    @(posedge ref_clk);
    #1 kbdActivity = 1'b1;
    @(posedge ref_clk);
    #1 kbdActivity = 1'b0;
    wt(2);
    outs(1'b1, 1'b1);
    repeat (3) begin
      wt(20);
      rw(8'hf6, 8'h03);
    end
    outs(1'b1, 1'b1);
    rw(8'hf7, 8'h60);
    wt(2);
    outs(1'b0, 1'b1);
    rr(8'hf7, 8'h50);
    rw(8'hf6, 8'h00);
    wt(100);
    outs(1'b1, 1'b1);
    rw(8'hf5, 8'h08);
    rw(8'hf6, 8'h01);
    wt(20);
    outs(1'b1, 1'b1);
    wt(15);
    outs(1'b0, 1'b1);
    pw(8'h2e, 8'haa);
    rw(8'hf6, 8'h00);
    wt(2);
    outs(1'b0, 1'b1);
    rd(8'h2f, 8'h00);
    rst(1'b1);
    pw(8'h2e, 8'h87);
    pw(8'h2e, 8'h87);
    rw(8'h07, 8'h08);
    rw(8'h30, 8'h01);
    rw(8'hf7, 8'h20);
    wt(2);
    outs(1'b1, 1'b0);
    wrap_up();
  end
endmodule
